// [core/tvi_top.sv]
// tvi_top: two-level vectored interrupt unit
// assumes: core pulses accept on vector fetch and ret on return
//
// Function
// - eleven sources: three timers, three pin groups, converter, pulse, serials, base
// - each source has its own high/low priority select bit
// - request passes only with global enable and own enable set
// - vectors start at 0003H, step eight bytes, end at 0053H
// - equal level requests served by fixed rank, ext0 first, ext2 last
// - timer0/1 overflow flags set, cleared by hardware on acceptance
// - timer2 overflow flag kept on acceptance, software clears it
// - conversion flag cleared on start, set on done, software clears
// - pulse overflow flag set, cleared by hardware on acceptance
// - serial done flags set by hardware, only software clears
// - pin groups of 4, 4, 6 pins with rising/falling selects
// - only pin groups and base timer may wake from stop
// - high preempts low; same or lower level waits for return
// - one instruction after return before any new acceptance
// - requests arriving during service stay pending, never lost
`timescale 1ns/10ps
module tvi_top #(
  parameter int N_EXT0 = tvi_pkg::EXT0_PINS,
  parameter int N_EXT1 = tvi_pkg::EXT1_PINS,
  parameter int N_EXT2 = tvi_pkg::EXT2_PINS
) (
  input  wire logic        ref_clk_in,          // 200 MHz system clock
  input  wire logic        reset_in,            // sync reset, high
  input  wire logic        global_irq_enable_in, // master enable
  input  wire logic [10:0] src_enable_in,       // per-source enables
  input  wire logic [10:0] priority_select_in,  // 1 = high level
  input  wire logic [13:0] ext_pins_in,         // async pins 0..3,4..7,8..13
  input  wire logic [13:0] pin_rising_select_in, // rising edge arm
  input  wire logic [13:0] pin_falling_select_in, // falling edge arm
  input  wire logic        timer0_ovf_in,       // overflow pulse
  input  wire logic        timer1_ovf_in,       // overflow pulse
  input  wire logic        timer2_ovf_in,       // overflow pulse
  input  wire logic        conv_start_in,       // conversion start pulse
  input  wire logic        conv_done_in,        // conversion done pulse
  input  wire logic        pulse_ovf_in,        // counter passed period
  input  wire logic        serial_a_done_in,    // port a rx/tx done
  input  wire logic        serial_b_done_in,    // port b rx/tx done
  input  wire logic        base_tick_in,        // base timer overflow
  input  wire logic [10:0] sw_flag_clear_in,    // software clear pulses
  input  wire logic        stop_mode_in,        // core is in stop
  input  wire logic        instr_end_in,        // instruction boundary
  input  wire logic        accept_in,           // core takes the vector
  input  wire logic        return_from_irq_in,  // return executed
  output logic             irq_req_out,         // request to core
  output logic [15:0]      irq_vector_out,      // vector address
  output logic [10:0]      flags_out,           // request flags
  output logic             wake_out,            // stop mode wake
  output logic [1:0]       active_level_out     // bit1 high, bit0 low
);
  localparam int NP = N_EXT0 + N_EXT1 + N_EXT2;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] first_set(input logic [10:0] v);
    logic [3:0] r;
    r = 4'hF;
    for (int i = tvi_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vec_of(input logic [3:0] s);
    return tvi_pkg::VEC_BASE + 16'(s) * tvi_pkg::VEC_STEP;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge unit
  // ----------------------------------------------------------------
  logic [NP-1:0] s1;
  logic [NP-1:0] s2;
  logic [NP-1:0] s3;
  logic [NP-1:0] agreed;
  logic [NP-1:0] next_agreed;

  always_comb begin
    next_agreed = (s2 & s3) | (agreed & (s2 | s3));
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      agreed <= '0;
    end else begin
      s1     <= ext_pins_in[NP-1:0];
      s2     <= s1;
      s3     <= s2;
      agreed <= next_agreed;
    end
  end

  tvi_if #(.N(NP)) eb ();
  assign eb.pin_sync = agreed;
  assign eb.rise_sel = pin_rising_select_in[NP-1:0];
  assign eb.fall_sel = pin_falling_select_in[NP-1:0];

  tvi_edge #(.N(NP)) u_edge (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .bus        (eb.edge_unit)
  );

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  logic [10:0] flags;
  logic [10:0] next_flags;
  logic [10:0] set_v;
  logic [10:0] hw_clr;
  logic [3:0]  sel;
  logic        sel_hi;
  logic        req_q;
  logic [3:0]  sel_q;

  always_comb begin
    set_v = '0;  // eleven request sources
    // pin edges latched per group
    set_v[tvi_pkg::SRC_EXT0]  = |eb.hit[N_EXT0-1:0];
    set_v[tvi_pkg::SRC_EXT1]  = |eb.hit[N_EXT0+N_EXT1-1:N_EXT0];
    set_v[tvi_pkg::SRC_EXT2]  = |eb.hit[NP-1:N_EXT0+N_EXT1];
    set_v[tvi_pkg::SRC_TMR0]  = timer0_ovf_in;
    set_v[tvi_pkg::SRC_TMR1]  = timer1_ovf_in;
    set_v[tvi_pkg::SRC_TMR2]  = timer2_ovf_in;
    set_v[tvi_pkg::SRC_CONV]  = conv_done_in;
    set_v[tvi_pkg::SRC_PULSE] = pulse_ovf_in;
    set_v[tvi_pkg::SRC_SERA]  = serial_a_done_in;
    set_v[tvi_pkg::SRC_SERB]  = serial_b_done_in;
    set_v[tvi_pkg::SRC_BASE]  = base_tick_in;
    hw_clr = '0;
    // auto clear only for flagged-auto sources
    // clear the source whose vector was offered, not a newer winner
    if (accept_in && req_q) begin
      hw_clr[sel_q] = tvi_pkg::AUTO_CLR[sel_q];
    end
    // conversion start clears its flag
    hw_clr[tvi_pkg::SRC_CONV] = hw_clr[tvi_pkg::SRC_CONV] | conv_start_in;
    // set wins over any clear, so nothing is lost
    next_flags = (flags & ~(hw_clr | sw_flag_clear_in)) | set_v;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      flags <= tvi_pkg::FLAG_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic [10:0] eligible;
  logic [3:0]  sel_h;
  logic [3:0]  sel_l;
  logic [1:0]  act;
  logic [1:0]  next_act;
  logic        hold;
  logic        next_hold;
  logic        may_take;

  always_comb begin
    // global and per-source gating
    eligible = global_irq_enable_in ? (flags & src_enable_in) : '0;
    // level split then fixed rank
    sel_h    = first_set(eligible & priority_select_in);
    sel_l    = first_set(eligible & ~priority_select_in);
    // high preempts low; low waits for any service
    if (!act[1] && sel_h != 4'hF) begin
      sel = sel_h;
    end else if (act == 2'b00 && sel_l != 4'hF) begin
      sel = sel_l;
    end else begin
      sel = 4'hF;
    end
    sel_hi   = priority_select_in[sel_q];  // level of offered vector
    // one instruction after return, taken at boundary
    may_take = !hold && !return_from_irq_in && instr_end_in
             && sel != 4'hF;
  end

  always_comb begin
    next_act  = act;
    next_hold = hold;
    if (return_from_irq_in) begin
      next_act  = act[1] ? {1'b0, act[0]} : 2'b00;
      next_hold = 1'b1;
    end else if (hold && instr_end_in) begin
      next_hold = 1'b0;
    end
    if (accept_in && req_q) begin
      if (sel_hi) begin
        next_act[1] = 1'b1;
      end else begin
        next_act[0] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      act  <= 2'b00;
      hold <= 1'b0;
    end else begin
      act  <= next_act;
      hold <= next_hold;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic [15:0] vec_q;
  logic        wake_q;
  logic        next_req;
  logic [3:0]  next_sel;
  logic [15:0] next_vec;
  logic        next_wake;

  always_comb begin
    next_req = may_take && !accept_in;
    next_sel = sel_q;
    next_vec = vec_q;
    // index and vector move together, so accept matches the offer
    if (sel != 4'hF) begin
      next_sel = sel;
      next_vec = vec_of(sel);
    end
    // only pin groups and base tick may wake
    next_wake = stop_mode_in && global_irq_enable_in
              && |(flags & src_enable_in & tvi_pkg::WAKE_MASK);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      req_q  <= 1'b0;
      sel_q  <= tvi_pkg::SRC_EXT0;
      vec_q  <= tvi_pkg::VEC_BASE;
      wake_q <= 1'b0;
    end else begin
      req_q  <= next_req;
      sel_q  <= next_sel;
      vec_q  <= next_vec;
      wake_q <= next_wake;
    end
  end

  assign irq_req_out      = req_q;
  assign irq_vector_out   = vec_q;
  assign flags_out        = flags;
  assign wake_out         = wake_q;
  assign active_level_out = act;
endmodule

// [core/tvi_pkg.sv]
// tvi_pkg: constants for the two-level vectored interrupt unit
// assumes: a single-clock core that fetches vectors and signals return
package tvi_pkg;
  localparam int          NUM_SRC      = 11;
  localparam int          SRC_W        = 4;
  localparam int          EXT0_PINS    = 4;
  localparam int          EXT1_PINS    = 4;
  localparam int          EXT2_PINS    = 6;
  localparam int          VEC_W        = 16;
  // source index equals polling rank minus one
  localparam logic [3:0]  SRC_EXT0     = 4'h0;
  localparam logic [3:0]  SRC_TMR0     = 4'h1;
  localparam logic [3:0]  SRC_EXT1     = 4'h2;
  localparam logic [3:0]  SRC_TMR1     = 4'h3;
  localparam logic [3:0]  SRC_SERA     = 4'h4;
  localparam logic [3:0]  SRC_TMR2     = 4'h5;
  localparam logic [3:0]  SRC_CONV     = 4'h6;
  localparam logic [3:0]  SRC_SERB     = 4'h7;
  localparam logic [3:0]  SRC_PULSE    = 4'h8;
  localparam logic [3:0]  SRC_BASE     = 4'h9;
  localparam logic [3:0]  SRC_EXT2     = 4'hA;
  localparam logic [15:0] VEC_BASE     = 16'h0003;
  localparam logic [15:0] VEC_STEP     = 16'h0008;
  localparam logic [10:0] WAKE_MASK    = 11'h605;
  localparam logic [10:0] FLAG_RST     = 11'h000;
  localparam logic [10:0] AUTO_CLR     = 11'h70F;
  localparam logic [10:0] EXT_MASK     = 11'h405;
  localparam int          CONV_DONE_BIT = 5;
  localparam int          RET_HOLD_CYC = 1;
endpackage

// [core/tvi_if.sv]
// tvi_if: edge-detector bundle between the top and its pin edge unit
// assumes: pins already synchronised to ref_clk_in
`timescale 1ns/10ps
interface tvi_if #(parameter int N = 14);
  logic [N-1:0] pin_sync;
  logic [N-1:0] rise_sel;
  logic [N-1:0] fall_sel;
  logic [N-1:0] hit;
  modport top  (output pin_sync, output rise_sel, output fall_sel,
                input hit);
  modport edge_unit (input pin_sync, input rise_sel, input fall_sel,
                output hit);
endinterface

// [core/tvi_edge.sv]
// tvi_edge: per-pin armed edge detection for the external groups
// assumes: pin_sync is the agreed value of a three-stage synchroniser
`timescale 1ns/10ps
module tvi_edge #(
  parameter int N = 14
) (
  input  wire logic ref_clk_in,  // system clock
  input  wire logic reset_in,    // sync reset, high
  tvi_if.edge_unit  bus          // pin levels and edge selects
);
  logic [N-1:0] prev;
  logic [N-1:0] next_prev;
  logic [N-1:0] hit;
  logic [N-1:0] next_hit;

  always_comb begin
    next_prev = bus.pin_sync;
    // rising, falling or both edges per pin
    next_hit  = (bus.pin_sync & ~prev & bus.rise_sel)
              | (~bus.pin_sync & prev & bus.fall_sel);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      prev <= '0;
      hit  <= '0;
    end else begin
      prev <= next_prev;
      hit  <= next_hit;
    end
  end

  assign bus.hit = hit;
endmodule

// [testbench/tvi_asserts.sv]
// tvi_asserts: port-level checks for tvi_top
// assumes: bound into every tvi_top, single clock domain
`timescale 1ns/10ps
module tvi_asserts (
  input wire logic        ref_clk_in,           // system clock
  input wire logic        reset_in,             // sync reset, high
  input wire logic        global_irq_enable_in, // master enable
  input wire logic        timer0_ovf_in,        // overflow pulse
  input wire logic        conv_start_in,        // start pulse
  input wire logic        conv_done_in,         // done pulse
  input wire logic        pulse_ovf_in,         // pulse overflow
  input wire logic [10:0] sw_flag_clear_in,     // software clears
  input wire logic        accept_in,            // vector taken
  input wire logic        return_from_irq_in,   // return
  input wire logic        irq_req_out,          // request
  input wire logic [15:0] irq_vector_out,       // vector
  input wire logic [10:0] flags_out,            // flags
  input wire logic        wake_out,             // wake
  input wire logic [1:0]  active_level_out      // levels
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  chk_gate_global: assert property (!global_irq_enable_in |=> !irq_req_out)
    else $error("request without global enable");
  chk_req_drop: assert property (accept_in |=> !irq_req_out)
    else $error("request held after accept");
  chk_vec_form: assert property (irq_req_out |->
    irq_vector_out[2:0] == 3'h3 && irq_vector_out <= 16'h0053)
    else $error("vector off the table");
  chk_t0_auto: assert property (accept_in && irq_vector_out == 16'h000B
    && !timer0_ovf_in |=> !flags_out[1])
    else $error("timer0 flag kept after accept");
  chk_t2_kept: assert property (accept_in && irq_vector_out == 16'h002B
    && !sw_flag_clear_in[5] |=> flags_out[5])
    else $error("timer2 flag cleared on accept");
  chk_serial_kept: assert property (flags_out[4] &&
    !sw_flag_clear_in[4] |=> flags_out[4])
    else $error("serial flag lost");
  chk_conv_start: assert property (conv_start_in && !conv_done_in
    |=> !flags_out[6])
    else $error("conversion flag not cleared on start");
  chk_pulse_set: assert property (pulse_ovf_in |=> flags_out[8])
    else $error("pulse flag not set");
  chk_wake_src: assert property (
    ((flags_out & 11'h605) == 11'h000)[*2] |-> !wake_out)
    else $error("wake without wake source");
  chk_ret_hold: assert property (return_from_irq_in |=> !irq_req_out)
    else $error("request right after return");
  chk_high_busy: assert property (active_level_out[1] |-> !irq_req_out)
    else $error("request during high service");
  cover property (active_level_out == 2'b11);
  cover property (wake_out);
  cover property (accept_in && irq_vector_out == 16'h0053);
endmodule
bind tvi_top tvi_asserts u_tvi_asserts (.*);

// [testbench/tvi_core_model.sv]
// tvi_core_model: core taking vectors and returning on command
// assumes: one instruction ends every cycle
`timescale 1ns/10ps
module tvi_core_model (
  input  wire logic        ref_clk_in,    // system clock
  input  wire logic        reset_in,      // sync reset, high
  input  wire logic        irq_req_in,    // request from unit
  input  wire logic [15:0] irq_vector_in, // offered vector
  input  wire logic [3:0]  delay_in,      // cycles before accept
  input  wire logic        ret_cmd_in,    // end current routine
  output logic             accept_out,    // vector taken
  output logic             ret_out,       // return executed
  output logic             instr_end_out, // instruction boundary
  output logic [15:0]      taken_out      // last vector taken
);
  // ----------------------------------------
  // accept and return
  // ----------------------------------------
  logic [3:0] wait_cnt;
  always_ff @(posedge ref_clk_in) begin
    accept_out <= 1'b0;
    ret_out <= ret_cmd_in;
    instr_end_out <= !reset_in;
    if (accept_out)
      taken_out <= irq_vector_in;
    if (reset_in) begin
      wait_cnt <= 4'h0;
      taken_out <= 16'h0000;
    end else if (!irq_req_in || accept_out) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= delay_in) begin
      accept_out <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// [testbench/testbench.sv]
// testbench: scenario tasks for tvi_top with a core model
// assumes: tvi_pkg, tvi_if, tvi_edge, tvi_top compiled first
`timescale 1ns/10ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ge = 1'b0;
  logic        stop = 1'b0;
  logic        ret_cmd = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic [8:0]  ev = 9'h000;
  logic [10:0] en = 11'h000;
  logic [10:0] pr = 11'h000;
  logic [10:0] clr = 11'h000;
  logic [13:0] pins = 14'h0020;
  logic [13:0] rsel = 14'h0101;
  logic [13:0] fsel = 14'h0020;
  logic        acc, ret, iend, req, wake;
  logic [15:0] vec, taken;
  logic [10:0] flags;
  logic [1:0]  act;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  localparam logic [10:0] auto_clr_src = 11'h70F;
  always #2.5 clk = ~clk;
  tvi_top u_tvi_top (.ref_clk_in(clk), .reset_in(rst),
    .global_irq_enable_in(ge), .src_enable_in(en),
    .priority_select_in(pr), .ext_pins_in(pins),
    .pin_rising_select_in(rsel), .pin_falling_select_in(fsel),
    .timer0_ovf_in(ev[0]), .timer1_ovf_in(ev[1]), .timer2_ovf_in(ev[2]),
    .conv_start_in(ev[3]), .conv_done_in(ev[4]), .pulse_ovf_in(ev[5]),
    .serial_a_done_in(ev[6]), .serial_b_done_in(ev[7]),
    .base_tick_in(ev[8]), .sw_flag_clear_in(clr), .stop_mode_in(stop),
    .instr_end_in(iend), .accept_in(acc), .return_from_irq_in(ret),
    .irq_req_out(req), .irq_vector_out(vec), .flags_out(flags),
    .wake_out(wake), .active_level_out(act));
  tvi_core_model u_tvi_core_model (.ref_clk_in(clk), .reset_in(rst),
    .irq_req_in(req), .irq_vector_in(vec), .delay_in(dly),
    .ret_cmd_in(ret_cmd), .accept_out(acc), .ret_out(ret),
    .instr_end_out(iend), .taken_out(taken));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic fire(input logic [8:0] m);
    ev = m;
    tick(1);
    ev = 9'h000;
  endtask
  task automatic wait_acc(input logic [15:0] v);
    for (int i = 0; i < 60 && acc !== 1'b1; i++)
      tick(1);
    if (acc !== 1'b1) begin
      err_total++;
      $display("[ERR] accept exp 1 got %b", acc);
    end
    tick(2);
    cmp("taken", v, taken);
  endtask
  task automatic do_ret(input logic [10:0] c);
    clr = c;
    ret_cmd = 1'b1;
    tick(1);
    clr = 11'h000;
    ret_cmd = 1'b0;
    tick(2);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_gate;
    en = 11'h002;
    fire(9'h001);
    tick(3);
    cmp("t0 flag", 16'h1, flags[1]);
    cmp("req off", 16'h0, req);
    ge = 1'b1;
    wait_acc(16'h000B);
    cmp("t0 clr", 16'h0, flags[1]);
    cmp("act", 16'h1, act);
    do_ret(11'h000);
  endtask
  task automatic s_rank;
    ge = 1'b0;
    en = 11'h7FF;
    pins = 14'h0101;
    fire(9'h1F7);
    tick(10);
    cmp("all flags", 16'h07FF, flags);
    ge = 1'b1;
    for (int i = 0; i < 11; i++) begin
      wait_acc(16'h0003 + 16'(8 * i));
      cmp("kept", 16'(!auto_clr_src[i]), flags[i]);
      do_ret(11'h001 << i);
    end
  endtask
  task automatic s_prio;
    dly = 4'h3;
    pr = 11'h010;
    fire(9'h002);
    wait_acc(16'h001B);
    fire(9'h040);
    wait_acc(16'h0023);
    cmp("both act", 16'h3, act);
    fire(9'h001);
    tick(4);
    cmp("low wait", 16'h0, req);
    cmp("pending", 16'h1, flags[1]);
    do_ret(11'h010);
    cmp("still low", 16'h0, req);
    do_ret(11'h000);
    wait_acc(16'h000B);
    do_ret(11'h000);
  endtask
  task automatic s_wake;
    dly = 4'hF;
    stop = 1'b1;
    fire(9'h014);
    tick(3);
    cmp("no wake", 16'h0, wake);
    cmp("conv set", 16'h1, flags[6]);
    fire(9'h008);
    tick(1);
    cmp("conv clr", 16'h0, flags[6]);
    fire(9'h100);
    tick(3);
    cmp("wake", 16'h1, wake);
    clr = 11'h7FF;
    tick(1);
    clr = 11'h000;
    pins = 14'h0121;
    tick(6);
    pins = 14'h0101;
    tick(8);
    cmp("ext1 wake", 16'h1, wake);
    clr = 11'h7FF;
    tick(1);
    clr = 11'h000;
    tick(3);
    cmp("idle", 16'h0, req);
    stop = 1'b0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    tick(16);
    rst = 1'b0;
    cmp("rst vec", 16'h0003, vec);
    cmp("rst flags", 16'h0000, flags);
    cmp("rst req", 16'h0, req);
    s_gate;
    s_rank;
    s_prio;
    s_wake;
    print_verdict;
  end
endmodule
